// >>> hw/master_xfer_ctrl.sv
// Bus-master transfer controller with AXI4-Lite register access.
// Assumes link pins are asynchronous; link clock is sampled, not used.
//
// Operation
// R1: Byte count field in control bits 31-16, read/write, cleared by resets; code clears it on device and warm reset, not bus reset.
// R2: Software keeps one transaction at most 64K minus one bytes.
// R3: Start field clears itself when the transaction finishes.
// R4: Software leaves start field alone while a transfer is active.
// R5: Bus reset during a transfer aborts it and flushes pending data.
// R6: Bus reset transitions raise a maskable processor interrupt.
// R7: Nonzero start code takes effect only with a nonzero byte count.
// R8: Code 0 idles and flushes; 1 mem write; 2,3 mem reads.
// R9: Codes 4-7 launch config write/read and port write/read.
// R10: Start field cleared by device, warm and bus reset.
// R11: Control bits 15-4 read zero and ignore writes.
// R12: Control bit 3 reads zero; software writes only zero.
// R13: Read-only current local address, cleared by device and warm reset.
// R14: Read-only current bus address, cleared by all three resets.
// R15: Bus master address gives word address for bus side.
// R16: Local master address autoincrements only low 24 bits, wrapping.
// R17: Read-only remaining byte count, cleared by all three resets.
// R18: Valid start loads current addresses and remaining count.
// R19: Each word advances addresses, decrements count, finishes at zero.
`timescale 1ns/1ps
module master_xfer_ctrl (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        warm_reset,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Link pins
	input  wire logic        bus_clk,
	input  wire logic        bus_reset_input,
	input  wire logic        bus_ack,
	input  wire logic [31:0] bus_rdata,
	output logic             bus_req,
	output logic [2:0]       bus_cmd,
	output logic [31:0]      bus_addr,
	output logic [31:0]      bus_wdata,
	// Local memory
	output logic [31:0]      local_addr,
	input  wire logic [31:0] local_rdata,
	output logic [31:0]      local_wdata,
	output logic             local_we,
	// Interrupt
	output logic             irq
);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_read_code(input logic [2:0] code);
		return code == master_xfer_pkg::prefetchable_mem_read_code ||
			code == master_xfer_pkg::nonprefetchable_mem_read_code ||
			code == master_xfer_pkg::cfg_read_code ||
			code == master_xfer_pkg::port_read_code;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Link pin sampling: clock, reset, ack, data all pass two flops
	logic [34:0] pins_sync;
	logic        bus_clk_rise;
	logic        bus_rst_s;
	logic        bus_ack_s;
	logic [31:0] bus_rdata_s;
	logic        bus_rst_prev;

	link_sampler #(.W(35)) sampler (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_in    ({bus_rdata, bus_ack, bus_reset_input, bus_clk}),
		.pin_sync  (pins_sync),
		.bit0_rise (bus_clk_rise)
	);

	assign bus_rst_s   = pins_sync[1];
	assign bus_ack_s   = pins_sync[2];
	assign bus_rdata_s = pins_sync[34:3];

	////////////////////////////////////////////////////////////////////
	// AXI handshake state
	logic        aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0]  aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        wr_fire;

	// Register and transfer state
	logic [15:0] byte_count_field, next_byte_count_field;
	logic [2:0]  start, next_start;
	logic [31:0] local_master_address, next_local_master_address;
	logic [29:0] master_word_address_field, next_master_word_address_field;
	logic [31:0] current_local_address, next_current_local_address;
	logic [31:0] current_bus_address, next_current_bus_address;
	logic [15:0] remaining_byte_count, next_remaining_byte_count;
	logic [1:0]  irq_status, next_irq_status, irq_mask, next_irq_mask;
	logic        next_bus_rst_prev;
	logic        next_local_we;
	logic [31:0] next_local_wdata, next_bus_wdata;
	master_xfer_pkg::xfer_state_t state, next_state;
	logic        word_move;
	logic        start_ok;

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign word_move     = state == master_xfer_pkg::ST_RUN &&
		bus_clk_rise && bus_ack_s && !bus_rst_s;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rresp   = s_axi_rresp;
		next_rdata   = s_axi_rdata;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_addr[7:2] <= master_xfer_pkg::OFF_IRQ_MASK[7:2])
				? master_xfer_pkg::RESP_OKAY : master_xfer_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_axi_rvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = master_xfer_pkg::RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				master_xfer_pkg::OFF_CONTROL:
					next_rdata = {byte_count_field, 13'h0000, start}; // R11 R12
				master_xfer_pkg::OFF_LOCAL_MASTER:
					next_rdata = local_master_address;
				master_xfer_pkg::OFF_BUS_MASTER:
					next_rdata = {master_word_address_field, 2'b00}; // R15
				master_xfer_pkg::OFF_CUR_LOCAL:
					next_rdata = current_local_address; // R13
				master_xfer_pkg::OFF_CUR_BUS:
					next_rdata = current_bus_address; // R14
				master_xfer_pkg::OFF_REMAINING:
					next_rdata = {16'h0000, remaining_byte_count}; // R17
				master_xfer_pkg::OFF_IRQ_STATUS:
					next_rdata = {30'h0000_0000, irq_status};
				master_xfer_pkg::OFF_IRQ_MASK:
					next_rdata = {30'h0000_0000, irq_mask};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = master_xfer_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'h0;
			s_axi_rdata  <= 32'h0000_0000;
		end else begin
			aw_held      <= next_aw_held;
			w_held       <= next_w_held;
			aw_addr      <= next_aw_addr;
			w_data       <= next_w_data;
			w_strb       <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp  <= next_rresp;
			s_axi_rdata  <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers and transfer engine
	logic [31:0] ctrl_w;
	logic [31:0] bus_ma_w;
	logic [15:0] step;

	always_comb begin
		ctrl_w = merge({byte_count_field, 13'h0000, start}, w_data, w_strb);
		bus_ma_w = merge({master_word_address_field, 2'b00}, w_data, w_strb);
		step   = (remaining_byte_count < master_xfer_pkg::WORD_BYTES)
			? remaining_byte_count : master_xfer_pkg::WORD_BYTES;
		start_ok = 1'b0;
		next_byte_count_field          = byte_count_field;
		next_start                     = start;
		next_local_master_address      = local_master_address;
		next_master_word_address_field = master_word_address_field;
		next_current_local_address     = current_local_address;
		next_current_bus_address       = current_bus_address;
		next_remaining_byte_count      = remaining_byte_count;
		next_irq_status                = irq_status;
		next_irq_mask                  = irq_mask;
		next_state                     = state;
		next_bus_rst_prev              = bus_rst_s;
		next_local_we                  = 1'b0;
		next_local_wdata               = local_wdata;
		next_bus_wdata                 = local_rdata;
		// Software clears first so a same-cycle event still sets
		if (wr_fire) begin
			case ({aw_addr[7:2], 2'b00})
				master_xfer_pkg::OFF_CONTROL: begin
					next_byte_count_field = ctrl_w[31:16]; // R1
					if (ctrl_w[2:0] == master_xfer_pkg::START_IDLE) begin
						next_start = master_xfer_pkg::START_IDLE; // R8
						next_state = master_xfer_pkg::ST_IDLE;
					end else if (state == master_xfer_pkg::ST_IDLE &&
						ctrl_w[31:16] != master_xfer_pkg::COUNT_ZERO) begin // R7
						// Bits 15-3 are never stored
						start_ok = 1'b1; // R11 R12
						next_start = ctrl_w[2:0]; // R8 R9
						next_state = master_xfer_pkg::ST_RUN;
						next_current_local_address = local_master_address; // R18
						next_current_bus_address =
							{master_word_address_field, 2'b00}; // R15 R18
						next_remaining_byte_count = ctrl_w[31:16]; // R18
					end
				end
				master_xfer_pkg::OFF_LOCAL_MASTER:
					next_local_master_address =
						merge(local_master_address, w_data, w_strb) &
						32'hffff_fffe;
				master_xfer_pkg::OFF_BUS_MASTER:
					next_master_word_address_field = bus_ma_w[31:2];
				master_xfer_pkg::OFF_IRQ_STATUS:
					next_irq_status = irq_status & ~w_data[1:0];
				master_xfer_pkg::OFF_IRQ_MASK:
					next_irq_mask = w_data[1:0];
				default: begin
					next_irq_mask = irq_mask;
				end
			endcase
		end
		if (word_move) begin
			next_current_local_address[23:0] =
				current_local_address[23:0] + 24'h00_0004; // R16 R19
			next_current_bus_address =
				current_bus_address + 32'h0000_0004; // R19
			next_remaining_byte_count = remaining_byte_count - step; // R19
			if (is_read_code(start)) begin
				next_local_we    = 1'b1;
				next_local_wdata = bus_rdata_s;
			end
			if (remaining_byte_count <= master_xfer_pkg::WORD_BYTES) begin
				next_start = master_xfer_pkg::START_IDLE; // R3 R19
				next_state = master_xfer_pkg::ST_IDLE;
				next_irq_status[master_xfer_pkg::IRQ_DONE] = 1'b1;
			end
		end
		if (bus_rst_s != bus_rst_prev) begin
			next_irq_status[master_xfer_pkg::IRQ_BUS_RESET] = 1'b1; // R6
		end
		if (bus_rst_s) begin
			next_start                = master_xfer_pkg::START_IDLE; // R10
			next_state                = master_xfer_pkg::ST_IDLE; // R5
			next_current_bus_address  = master_xfer_pkg::RESET_WORD; // R14
			next_remaining_byte_count = master_xfer_pkg::COUNT_ZERO; // R17
			next_local_we             = 1'b0; // R5
		end
		if (warm_reset) begin
			next_byte_count_field          = master_xfer_pkg::COUNT_ZERO; // R1
			next_start                     = master_xfer_pkg::START_IDLE; // R10
			next_state                     = master_xfer_pkg::ST_IDLE;
			next_local_master_address      = master_xfer_pkg::RESET_WORD;
			next_master_word_address_field = 30'h0000_0000;
			next_current_local_address     = master_xfer_pkg::RESET_WORD; // R13
			next_current_bus_address       = master_xfer_pkg::RESET_WORD; // R14
			next_remaining_byte_count      = master_xfer_pkg::COUNT_ZERO; // R17
			next_local_we                  = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			byte_count_field          <= 16'h0000;
			start                     <= 3'h0;
			local_master_address      <= 32'h0000_0000;
			master_word_address_field <= 30'h0000_0000;
			current_local_address     <= 32'h0000_0000;
			current_bus_address       <= 32'h0000_0000;
			remaining_byte_count      <= 16'h0000;
			irq_status                <= 2'h0;
			irq_mask                  <= 2'h0;
			state                     <= master_xfer_pkg::ST_IDLE;
			bus_rst_prev              <= 1'b0;
			local_we                  <= 1'b0;
			local_wdata               <= 32'h0000_0000;
			bus_wdata                 <= 32'h0000_0000;
		end else begin
			byte_count_field          <= next_byte_count_field;
			start                     <= next_start;
			local_master_address      <= next_local_master_address;
			master_word_address_field <= next_master_word_address_field;
			current_local_address     <= next_current_local_address;
			current_bus_address       <= next_current_bus_address;
			remaining_byte_count      <= next_remaining_byte_count;
			irq_status                <= next_irq_status;
			irq_mask                  <= next_irq_mask;
			state                     <= next_state;
			bus_rst_prev              <= next_bus_rst_prev;
			local_we                  <= next_local_we;
			local_wdata               <= next_local_wdata;
			bus_wdata                 <= next_bus_wdata;
		end
	end

	assign bus_req    = state == master_xfer_pkg::ST_RUN;
	assign bus_cmd    = start;
	assign bus_addr   = current_bus_address;
	assign local_addr = current_local_address;
	assign irq        = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////
	sequence last_word_s;
		word_move && remaining_byte_count <= 16'h0004 && !warm_reset;
	endsequence
	sequence ctrl_write_s;
		wr_fire && aw_addr == 8'h00 && !bus_rst_s && !warm_reset;
	endsequence

	count_warm_clear_a: assert property ( // R1
		warm_reset |=> byte_count_field == 16'h0000 && start == 3'h0)
		else $error("count or start survived warm reset");
	start_self_clear_a: assert property ( // R3
		last_word_s and !bus_rst_s |=> start == 3'h0 && !bus_req && irq_status[1])
		else $error("start not cleared after last word");
	bus_reset_abort_a: assert property ( // R5
		bus_rst_s |=> !bus_req && start == 3'h0 && !local_we)
		else $error("bus reset did not abort transfer");
	reset_edge_irq_a: assert property ( // R6
		bus_rst_s != bus_rst_prev |=> irq_status[0])
		else $error("bus reset transition not flagged");
	zero_count_a: assert property ( // R7
		ctrl_write_s and (ctrl_w[31:16] == 16'h0000) |=> !bus_req)
		else $error("transfer began with zero count");
	cmd_code_a: assert property ( // R9
		ctrl_write_s and (state == master_xfer_pkg::ST_IDLE &&
		ctrl_w[31:16] != 16'h0000 && ctrl_w[2:0] != 3'h0)
		|=> bus_req && bus_cmd == $past(ctrl_w[2:0]))
		else $error("start code not launched");
	ctrl_reserved_a: assert property ( // R11
		s_axi_rvalid && $past(s_axi_araddr[7:2] == 6'h00 && s_axi_arready)
		|-> s_axi_rdata[15:3] == 13'h0000)
		else $error("control reserved bits read nonzero");
	start_load_a: assert property ( // R18
		start_ok && !bus_rst_s && !warm_reset |=>
		current_local_address == $past(local_master_address) &&
		remaining_byte_count == $past(ctrl_w[31:16]))
		else $error("start did not load current registers");
	word_advance_a: assert property ( // R19
		word_move && remaining_byte_count > 16'h0004 && !warm_reset
		|=> remaining_byte_count == $past(remaining_byte_count) - 16'h0004
		&& current_bus_address == $past(current_bus_address) + 32'h4)
		else $error("word move did not advance");
	bus_reset_clear_a: assert property ( // R14
		bus_rst_s |=> current_bus_address == 32'h0 &&
		remaining_byte_count == 16'h0000)
		else $error("bus reset left current registers set");

endmodule

// >>> common/master_xfer_pkg.sv
// Constants shared by the bus-master transfer controller and its bench.
// Assumes a single 50 MHz register clock and AXI4-Lite register access.
package master_xfer_pkg;

	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL      = 8'h00;
	localparam logic [7:0] OFF_LOCAL_MASTER = 8'h04;
	localparam logic [7:0] OFF_BUS_MASTER   = 8'h08;
	localparam logic [7:0] OFF_CUR_LOCAL    = 8'h0c;
	localparam logic [7:0] OFF_CUR_BUS      = 8'h10;
	localparam logic [7:0] OFF_REMAINING    = 8'h14;
	localparam logic [7:0] OFF_IRQ_STATUS   = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK     = 8'h1c;

	// Control register fields
	localparam int COUNT_LSB = 16;
	localparam int COUNT_W   = 16;
	localparam int START_LSB = 0;
	localparam int START_W   = 3;

	// Reset values
	localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
	localparam logic [2:0]  START_IDLE  = 3'h0;
	localparam logic [15:0] COUNT_ZERO  = 16'h0000;

	// Start codes
	localparam logic [2:0] mem_write_code                = 3'h1;
	localparam logic [2:0] prefetchable_mem_read_code    = 3'h2;
	localparam logic [2:0] nonprefetchable_mem_read_code = 3'h3;
	localparam logic [2:0] cfg_write_code                = 3'h4;
	localparam logic [2:0] cfg_read_code                 = 3'h5;
	localparam logic [2:0] port_write_code               = 3'h6;
	localparam logic [2:0] port_read_code                = 3'h7;

	// Word step and local autoincrement span
	localparam logic [15:0] WORD_BYTES = 16'h0004;
	localparam int          LOCAL_WRAP_W = 24;

	// Interrupt status bits
	localparam int IRQ_BUS_RESET = 0;
	localparam int IRQ_DONE      = 1;
	localparam int IRQ_W         = 2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} xfer_state_t;

endpackage

// >>> hw/link_sampler.sv
// Two-flop synchroniser for link pins plus rising-edge finder on bit 0.
// Assumes inputs are asynchronous to aclk; bit 0 carries the link clock.
`timescale 1ns/1ps
module link_sampler #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Raw pins
	input  wire logic [W-1:0] pin_in,
	// Synchronised view
	output logic      [W-1:0] pin_sync,
	output logic              bit0_rise
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic         bit0_prev;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_stage2;
	logic         next_bit0_prev;

	always_comb begin
		next_stage1    = pin_in;
		next_stage2    = stage1;
		next_bit0_prev = stage2[0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1    <= '0;
			stage2    <= '0;
			bit0_prev <= 1'b0;
		end else begin
			stage1    <= next_stage1;
			stage2    <= next_stage2;
			bit0_prev <= next_bit0_prev;
		end
	end

	assign pin_sync  = stage2;
	assign bit0_rise = stage2[0] & ~bit0_prev;

endmodule

// >>> dv/bus_target_model.sv
// Far-side bus target: makes the link clock during frames and acks words.
// Assumes bus_req from the controller; ack_en lets the bench stall it.
`timescale 1ns/1ps
module bus_target_model (
	// Control
	input  wire logic        bus_req,
	input  wire logic        ack_en,
	// Link side
	output logic             bus_clk,
	output logic             bus_ack,
	output logic [31:0]      bus_rdata
);
	initial begin
		bus_clk = 1'b0;
		bus_rdata = 32'h5a5a_0f0f;
		#3;
		forever begin
			#80;
			// Clock stands still between frames
			bus_clk = bus_req ? ~bus_clk : 1'b0;
		end
	end
	// New pattern every fall so a stale word never passes for fresh
	always @(negedge bus_clk) bus_rdata <= {bus_rdata[30:0], ~bus_rdata[31]};
	assign bus_ack = ack_en & bus_req;
endmodule

// >>> dv/master_xfer_ctrl_tb.sv
// Self-checking bench for the bus-master transfer controller.
// Assumes AXI4-Lite register access and the target model on the link.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module master_xfer_ctrl_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, warm_reset = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, local_rdata = 32'h0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        bus_reset_input = 1'b0, ack_en = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, bus_clk, bus_ack, bus_req, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, bus_rdata, rd_last, lm, bm;
	logic [2:0]  bus_cmd;
	logic [31:0] bus_addr, local_addr, bus_wdata, local_wdata;
	logic [31:0] lr_prev = 32'h0;
	logic        local_we;
	logic [1:0]  bexp_q[$];
	logic [1:0]  bnote;
	int          we_count = 0, we_exp = 0;
	logic [34:0] exp_q[$];
	logic [34:0] note;
	int          miscompares = 0, num_checks = 0;
	integer      seed = 32'h6f4bd7cb;
	localparam logic [1:0] OK = master_xfer_pkg::RESP_OKAY;

	always #10 aclk = ~aclk;
	always @(posedge aclk) local_rdata <= $random(seed);

	master_xfer_ctrl u_master_xfer_ctrl (
		.aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .bus_clk(bus_clk),
		.bus_reset_input(bus_reset_input), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .bus_req(bus_req), .bus_cmd(bus_cmd),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .local_addr(local_addr),
		.local_rdata(local_rdata), .local_wdata(local_wdata),
		.local_we(local_we), .irq(irq)
	);
	bus_target_model u_bus_target_model (
		.bus_req(bus_req), .ack_en(ack_en), .bus_clk(bus_clk),
		.bus_ack(bus_ack), .bus_rdata(bus_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		bexp_q.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) begin
			miscompares++;
			stop_test();
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Expectation is queued here; the monitor below does the comparing
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er, input logic chk);
		int n;
		exp_q.push_back({chk, er, ed});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) begin
			miscompares++;
			stop_test();
		end
		rd_last = s_axi_rdata;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (note[34]) begin
				`CHK("rdata", note[31:0], s_axi_rdata)
				`CHK("rresp", note[33:32], s_axi_rresp)
			end
		end
		if (s_axi_bvalid && s_axi_bready && bexp_q.size() > 0) begin
			bnote = bexp_q.pop_front();
			`CHK("bresp", bnote, s_axi_bresp)
		end
		lr_prev <= local_rdata;
		if (local_we) begin
			we_count++;
			`CHK("local_wdata", bus_rdata, local_wdata)
		end
		if (bus_req) `CHK("bus_wdata", lr_prev, bus_wdata)
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(master_xfer_pkg::OFF_CONTROL, 32'h0, OK, 1);
		rd(master_xfer_pkg::OFF_CUR_LOCAL, 32'h0, OK, 1);
		rd(master_xfer_pkg::OFF_CUR_BUS, 32'h0, OK, 1);
		wr(master_xfer_pkg::OFF_CONTROL, 32'h1234_fff0, OK);
		rd(master_xfer_pkg::OFF_CONTROL, 32'h1234_0000, OK, 1);
		wr(master_xfer_pkg::OFF_CONTROL, 32'h0000_0002, OK);
		rd(master_xfer_pkg::OFF_CONTROL, 32'h0, OK, 1);
		wr(master_xfer_pkg::OFF_IRQ_MASK, 32'h3, OK);
		for (int c = 1; c < 8; c++) begin
			lm = $random(seed);
			lm[23:0] = 24'hfffffc;
			bm = $random(seed);
			ack_en <= 1'b0;
			wr(master_xfer_pkg::OFF_LOCAL_MASTER, lm, OK);
			wr(master_xfer_pkg::OFF_BUS_MASTER, bm, OK);
			wr(master_xfer_pkg::OFF_CONTROL, {16'h0008, 13'h0, c[2:0]}, OK);
			rd(master_xfer_pkg::OFF_CONTROL, {16'h8, 13'h0, c[2:0]}, OK, 1);
			rd(master_xfer_pkg::OFF_CUR_LOCAL, lm, OK, 1);
			rd(master_xfer_pkg::OFF_CUR_BUS, bm & ~32'h3, OK, 1);
			rd(master_xfer_pkg::OFF_REMAINING, 32'h8, OK, 1);
			`CHK("bus_cmd", c[2:0], bus_cmd)
			`CHK("bus_addr", bm & ~32'h3, bus_addr)
			`CHK("local_addr", lm, local_addr)
			we_count = 0;
			we_exp = (c == 2 || c == 3 || c == 5 || c == 7) ? 2 : 0;
			ack_en <= 1'b1;
			rd_last = 32'h7;
			for (int n = 0; n < 400 && rd_last[2:0] != 3'h0; n++)
				rd(master_xfer_pkg::OFF_CONTROL, 32'h0, OK, 0);
			`CHK("start_field", 3'h0, rd_last[2:0])
			if (rd_last[2:0] !== 3'h0) stop_test();
			`CHK("local_we", we_exp, we_count)
			rd(master_xfer_pkg::OFF_CUR_LOCAL, {lm[31:24], 24'h4}, OK, 1);
			rd(master_xfer_pkg::OFF_CUR_BUS, (bm & ~32'h3) + 8, OK, 1);
			rd(master_xfer_pkg::OFF_REMAINING, 32'h0, OK, 1);
			`CHK("irq_done", 1'b1, irq)
			wr(master_xfer_pkg::OFF_IRQ_STATUS, 32'h2, OK);
			`CHK("irq_clear", 1'b0, irq)
		end
		ack_en <= 1'b0;
		wr(master_xfer_pkg::OFF_CONTROL, 32'h0010_0006, OK);
		wr(master_xfer_pkg::OFF_CONTROL, 32'h0010_0000, OK);
		rd(master_xfer_pkg::OFF_CONTROL, 32'h0010_0000, OK, 1);
		`CHK("bus_req", 1'b0, bus_req)
		wr(master_xfer_pkg::OFF_IRQ_STATUS, 32'h3, OK);
		wr(master_xfer_pkg::OFF_CONTROL, 32'h0010_0001, OK);
		bus_reset_input <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(master_xfer_pkg::OFF_CONTROL, 32'h0010_0000, OK, 1);
		rd(master_xfer_pkg::OFF_CUR_BUS, 32'h0, OK, 1);
		rd(master_xfer_pkg::OFF_REMAINING, 32'h0, OK, 1);
		`CHK("bus_req", 1'b0, bus_req)
		`CHK("irq_bus_reset", 1'b1, irq)
		wr(master_xfer_pkg::OFF_IRQ_MASK, 32'h2, OK);
		`CHK("irq_masked", 1'b0, irq)
		wr(master_xfer_pkg::OFF_IRQ_STATUS, 32'h3, OK);
		bus_reset_input <= 1'b0;
		repeat (6) @(posedge aclk);
		rd(master_xfer_pkg::OFF_IRQ_STATUS, 32'h1, OK, 1);
		warm_reset <= 1'b1;
		@(posedge aclk);
		warm_reset <= 1'b0;
		@(posedge aclk);
		rd(master_xfer_pkg::OFF_CONTROL, 32'h0, OK, 1);
		rd(master_xfer_pkg::OFF_CUR_LOCAL, 32'h0, OK, 1);
		rd(8'h20, 32'h0, master_xfer_pkg::RESP_SLVERR, 1);
		wr(8'h20, 32'hffff_ffff, master_xfer_pkg::RESP_SLVERR);
		repeat (2) @(posedge aclk);
		stop_test();
	end
endmodule
